// File: hdl/bcw_regs.svh
// Constants for the external bus clock, wait stretch and pin control block
`ifndef BCW_REGS_SVH
`define BCW_REGS_SVH
`define BCW_OSC_PER_BUS 4
`define BCW_LOW_PHASE 2'h2
`define BCW_HIGH_PHASE 2'h2
`define BCW_STRETCH_CYCLES 3'h4
`define BCW_MODE_SINGLE 2'h0
`define BCW_MODE_EXPANDED 2'h1
`define BCW_MODE_BOOT 2'h2
`define BCW_MODE_TEST 2'h3
`define BCW_LIR_PULSE 2'h1
`endif

// File: hdl/bcw_pkg.sv
// Types shared by the bus clock and pin control block
`default_nettype none
package bcw_pkg;
  typedef enum logic [1:0] {
    BCW_SINGLE,
    BCW_EXPANDED,
    BCW_BOOT,
    BCW_TEST
  } bcw_mode_e;
  typedef enum logic [1:0] {
    BCW_PH_LOW,
    BCW_PH_HIGH,
    BCW_PH_STRETCH
  } bcw_phase_e;
endpackage
`default_nettype wire

// File: hdl/bcw_open_drain.sv
// Open-drain pin driver with a registered pull-low request
`default_nettype none
module bcw_open_drain (
  input wire logic ref_clk, // Clock
  input wire logic resetn, // Async reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic pull_low, // Request to pull the pin low
  output logic pin_out, // Pin output value, always low
  output logic pin_oe // Pin driven while high
);
  typedef struct packed {
    logic oe;
  } bcw_od_s;
  bcw_od_s st_r;
  bcw_od_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.oe = pull_low;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
  assign pin_out = 1'b0;
  assign pin_oe = st_r.oe;
endmodule // bcw_open_drain

// File: hdl/bcw_bus_pins.sv
// External bus clock generator with wait stretching and pin muxing
`include "bcw_regs.svh"
`default_nettype none
module bcw_bus_pins (
  input wire logic ref_clk, // Oscillator clock, four times bus rate
  input wire logic resetn, // Reset pin input, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic mode_select_first, // First mode pin level
  input wire logic mode_select_second, // Second mode pin level / standby supply
  input wire logic wait_in, // Stretch request from slow device
  input wire logic irq_n, // Maskable interrupt request, active low
  input wire logic nonmaskable_interrupt_input, // Second interrupt input, active low
  input wire logic clock_monitor_fail, // Clock monitor failure
  input wire logic watchdog_fail, // Watchdog failure
  input wire logic core_mask_i, // Interrupt mask bit from core
  input wire logic core_mask_x, // Second interrupt mask bit from core
  input wire logic instr_start, // Core starts an instruction
  input wire logic [15:0] core_addr, // Core address
  input wire logic [7:0] core_wdata, // Core write data
  input wire logic core_write, // Core cycle is a write
  input wire logic [7:0] port_b_gp, // General port B value
  input wire logic [7:0] port_f_gp, // General port F value
  input wire logic [7:0] port_c_gp_out, // General port C output
  input wire logic [7:0] port_c_gp_oe, // General port C enables
  input wire logic [7:0] port_c_in, // Port C pin levels
  output logic bus_clock, // Bus clock out
  output logic inverted_bus_strobe, // Inverted bus clock
  output logic buffered_oscillator_out, // Oscillator copy
  output logic reset_pin_out, // Reset pin drive value
  output logic reset_pin_oe, // Reset pin pulled low while high
  output logic marker_out, // First mode pin drive value
  output logic marker_oe, // First mode pin pulled low while high
  output bcw_pkg::bcw_mode_e op_mode, // Latched operating mode
  output logic standby_active, // Standby supply feeds RAM
  output logic irq_pending, // Maskable request to core
  output logic nmi_pending, // Second request to core, masked by core_mask_x
  output logic rd_wr_n, // Transfer direction, high for read
  output logic [7:0] port_b_out, // Port B pins
  output logic [7:0] port_f_out, // Port F pins
  output logic [7:0] port_c_out, // Port C output values
  output logic [7:0] port_c_oe, // Port C enables
  output logic [7:0] core_rdata, // Data captured from bus
  output logic bus_cycle_end // One-cycle pulse as bus clock falls
);
  import bcw_pkg::*;
  typedef struct packed {
    bcw_phase_e ph;
    logic [2:0] cnt;
    logic e;
    logic in_reset;
    bcw_mode_e mode;
    logic [1:0] irq_sync;
    logic [1:0] nmi_sync;
    logic [1:0] lir_cnt;
    logic rw;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic endp;
  } bcw_s;
  bcw_s st_r;
  bcw_s st_nxt;
  logic expanded;
  logic lir_pull;

  always_comb begin
    st_nxt = st_r;
    st_nxt.endp = 1'b0;
    st_nxt.in_reset = 1'b0;
    // Mode caught on first enabled edge after release
    // Muxes read the mode, so they stay general purpose until it is caught
    if (st_r.in_reset) begin
      st_nxt.mode = bcw_mode_e'({mode_select_second, mode_select_first});
    end
    // Two flops only; asynchronous inputs
    st_nxt.irq_sync = {st_r.irq_sync[0], ~irq_n};
    st_nxt.nmi_sync = {st_r.nmi_sync[0], ~nonmaskable_interrupt_input};
    unique case (st_r.ph)
      BCW_PH_LOW: begin
        if (st_r.cnt == 3'(`BCW_LOW_PHASE - 2'h1)) begin
          st_nxt.ph = BCW_PH_HIGH;
          st_nxt.cnt = '0;
          st_nxt.e = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 3'h1;
        end
      end
      BCW_PH_HIGH: begin
        if (st_r.cnt == 3'(`BCW_HIGH_PHASE - 2'h1)) begin
          st_nxt.cnt = '0;
          st_nxt.ph = BCW_PH_LOW;
          st_nxt.e = 1'b0;
          st_nxt.endp = 1'b1;
          // Reads only; a write cycle leaves the last read byte standing
          if (st_r.rw) begin
            st_nxt.rdata = port_c_in; // Data sampled while bus clock high
          end
        end else begin
          st_nxt.cnt = st_r.cnt + 3'h1;
        end
        // Wait sampled at the first oscillator edge after the bus clock rises
        // Only the first high cycle looks at wait; a later request is missed
        if (st_r.cnt == 3'h0 && wait_in) begin
          st_nxt.ph = BCW_PH_STRETCH;
          st_nxt.cnt = 3'h1;
          st_nxt.e = 1'b1;
          st_nxt.endp = 1'b0;
        end
      end
      BCW_PH_STRETCH: begin
        // Total high time is two normal plus four stretch cycles
        if (st_r.cnt == 3'(`BCW_STRETCH_CYCLES)) begin
          st_nxt.ph = BCW_PH_HIGH;
          st_nxt.cnt = 3'(`BCW_HIGH_PHASE - 2'h1);
          st_nxt.e = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 3'h1;
        end
      end
      default: begin
        st_nxt.ph = BCW_PH_LOW;
        st_nxt.cnt = '0;
      end
    endcase
    // New address and direction launched as the bus clock falls
    if (st_nxt.endp) begin
      st_nxt.addr = core_addr;
      st_nxt.wdata = core_wdata;
      st_nxt.rw = ~core_write;
    end
    // Marker pulse held for a fixed span
    // The pin register adds a cycle, so the pull follows the start by two edges
    if (instr_start) begin
      st_nxt.lir_cnt = `BCW_LIR_PULSE;
    end else if (st_r.lir_cnt != 2'h0) begin
      st_nxt.lir_cnt = st_r.lir_cnt - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.in_reset <= 1'b1;
      st_r.rw <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign expanded = (st_r.mode == BCW_EXPANDED) || (st_r.mode == BCW_TEST);
  assign lir_pull = !st_r.in_reset && st_r.lir_cnt != 2'h0;

  // A one-cycle failure flag still gives a whole cycle of pull on the pin
  bcw_open_drain u_reset_od (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pull_low(clock_monitor_fail | watchdog_fail),
    .pin_out(reset_pin_out),
    .pin_oe(reset_pin_oe)
  );
  bcw_open_drain u_marker_od (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pull_low(lir_pull),
    .pin_out(marker_out),
    .pin_oe(marker_oe)
  );

  assign bus_clock = st_r.e;
  assign inverted_bus_strobe = ~st_r.e;
  // Clock passes straight through; a flop here would halve its rate
  assign buffered_oscillator_out = ref_clk;
  assign op_mode = st_r.mode;
  // Level only; switching the RAM onto the standby supply happens outside
  assign standby_active = !st_r.in_reset && mode_select_second;
  // Mask applied after the synchroniser, so a mask change acts at once
  assign irq_pending = st_r.irq_sync[1] && !core_mask_i;
  assign nmi_pending = st_r.nmi_sync[1] && !core_mask_x;
  // Pin muxes; general port values pass through outside the bus modes
  always_comb begin
    port_f_out = port_f_gp;
    if (st_r.mode == BCW_EXPANDED) begin
      port_f_out = st_r.addr[7:0];
    end
    if (expanded) begin
      rd_wr_n = st_r.rw;
      port_b_out = st_r.addr[15:8];
      // Bus drives data only in the high phase of a write
      port_c_out = st_r.wdata;
      port_c_oe = {8{st_r.e && !st_r.rw}};
    end else begin
      rd_wr_n = 1'b1;
      port_b_out = port_b_gp;
      port_c_out = port_c_gp_out;
      port_c_oe = port_c_gp_oe;
    end
  end
  assign core_rdata = st_r.rdata;
  // Core may present its next request as soon as this pulse is seen
  assign bus_cycle_end = st_r.endp;
endmodule // bcw_bus_pins
`default_nettype wire

// File: verification/bcw_bus_pins_asserts.sv
// Checker for the bus clock, stretch and pin rules
`default_nettype none
module bcw_bus_pins_chk (
  input wire logic ref_clk, // Clock
  input wire logic resetn, // Reset
  input wire logic clk_en, // Clock enable
  input wire logic bus_clock, // Bus clock
  input wire logic inverted_bus_strobe, // Strobe
  input wire logic buffered_oscillator_out, // Osc copy
  input wire logic wait_in, // Stretch
  input wire logic clock_monitor_fail, // Fail
  input wire logic watchdog_fail, // Fail
  input wire logic reset_pin_out, // Reset drive
  input wire logic reset_pin_oe, // Reset enable
  input wire logic instr_start, // Start
  input wire logic marker_out, // Marker drive
  input wire logic marker_oe, // Marker enable
  input wire bcw_pkg::bcw_mode_e op_mode, // Mode
  input wire logic [15:0] core_addr, // Address
  input wire logic [7:0] port_b_out, // Port B
  input wire logic [7:0] port_f_out, // Port F
  input wire logic [7:0] port_c_oe, // Port C enables
  input wire logic rd_wr_n, // Direction
  input wire logic irq_n, // Irq
  input wire logic core_mask_i, // Mask
  input wire logic irq_pending, // Pending
  input wire logic nonmaskable_interrupt_input, // Nmi
  input wire logic core_mask_x, // Mask
  input wire logic nmi_pending // Pending
);
  timeunit 1ns;
  timeprecision 100ps;
  import bcw_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  // A frozen clock enable stalls every counted span, so such attempts are dropped
  default disable iff (!resetn || !clk_en);
  wire logic exp_m = op_mode == BCW_EXPANDED;
  strobe_inv_a: assert property (inverted_bus_strobe == !bus_clock) else $error("strobe mismatch");
  osc_copy_a: assert property (buffered_oscillator_out == ref_clk) else $error("osc copy");
  low_phase_a: assert property ($fell(bus_clock) |=> !bus_clock ##1 bus_clock) else $error("low phase");
  fast_fall_a: assert property ($rose(bus_clock) && !wait_in |=> bus_clock ##1 !bus_clock) else $error("high");
  stretch_a: assert property ($rose(bus_clock) && wait_in |=> bus_clock [*5] ##1 !bus_clock) else $error("stretch");
  fail_pull_a: assert property (clock_monitor_fail || watchdog_fail |=> reset_pin_oe && !reset_pin_out)
    else $error("reset pull");
  marker_a: assert property (instr_start |=> ##1 (marker_oe && !marker_out)) else $error("marker");
  addr_out_a: assert property ($fell(bus_clock) && exp_m |->
    {port_b_out, port_f_out} == $past(core_addr)) else $error("address");
  data_dir_a: assert property (exp_m |-> port_c_oe == {8{bus_clock && !rd_wr_n}})
    else $error("data drive");
  rw_idle_a: assert property (op_mode == BCW_SINGLE || op_mode == BCW_BOOT |-> rd_wr_n) else $error("rw");
  irq_sync_a: assert property (!irq_n [*3] ##0 !core_mask_i |-> irq_pending) else $error("irq");
  nmi_mask_a: assert property (core_mask_x |-> !nmi_pending) else $error("nmi mask");
endmodule // bcw_bus_pins_chk
// Checked above: reset pull address bytes data bus
bind bcw_bus_pins bcw_bus_pins_chk u_chk (.*);
`default_nettype wire

// File: verification/bcw_slow_mem.sv
// Slow external memory on the expanded bus
`default_nettype none
module bcw_slow_mem (
  input wire logic ref_clk, // Clock
  input wire logic slow, // Ask for stretch
  input wire logic bus_clock, // Bus clock
  input wire logic rd_wr_n, // Direction
  input wire logic [7:0] port_f_out, // Low address
  input wire logic [7:0] port_c_out, // Write data
  input wire logic [7:0] port_c_oe, // Data enables
  output logic wait_in, // Stretch request
  output logic [7:0] port_c_in // Pin levels
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  assign wait_in = slow && bus_clock;
  // No pull-ups: a released bus toggles so stale data cannot pass
  assign port_c_in = (port_c_oe == 8'hFF) ? port_c_out : (bus_clock && rd_wr_n) ? mem[port_f_out] : ~last;
  always @(posedge ref_clk) begin
    if (port_c_oe == 8'hFF) mem[port_f_out] <= port_c_out;
    last <= port_c_in;
  end
endmodule // bcw_slow_mem
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the bus clock and pin block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bcw_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] d; logic w; logic s;} bcw_row_s;
  logic ref_clk = 0, resetn = 0, mode_select_first = 1, mode_select_second = 0, irq_n = 1, instr_start = 0;
  logic nonmaskable_interrupt_input = 1, clock_monitor_fail = 0, watchdog_fail = 0, core_mask_i = 1, core_mask_x = 1;
  logic core_write = 0, slow = 0, wait_in, bus_clock, marker_oe, reset_pin_oe, irq_pending, nmi_pending;
  logic rd_wr_n, bus_cycle_end, standby_active, clk_en = 1;
  logic [15:0] core_addr = 16'h0000;
  logic [7:0] core_wdata = 8'h00, port_b_gp = 8'h5A, port_c_in, port_b_out, port_f_out, port_c_out, port_c_oe;
  logic [7:0] core_rdata;
  bcw_mode_e op_mode;
  int n_mismatch = 0, total_checks = 0;
  bcw_row_s rows [4] = '{'{16'h12A0, 8'hA5, 1'b1, 1'b0}, '{16'h34FF, 8'h3C, 1'b1, 1'b1},
                         '{16'h12A0, 8'hA5, 1'b0, 1'b1}, '{16'h34FF, 8'h3C, 1'b0, 1'b0}};
  bcw_bus_pins dut (.ref_clk, .resetn, .clk_en, .mode_select_first, .mode_select_second, .wait_in, .irq_n,
    .nonmaskable_interrupt_input, .clock_monitor_fail, .watchdog_fail, .core_mask_i, .core_mask_x, .instr_start,
    .core_addr, .core_wdata, .core_write, .port_b_gp, .port_f_gp(8'h00), .port_c_gp_out(8'h00),
    .port_c_gp_oe(8'h00), .port_c_in, .bus_clock, .inverted_bus_strobe(), .buffered_oscillator_out(),
    .reset_pin_out(), .reset_pin_oe, .marker_out(), .marker_oe, .op_mode, .standby_active, .irq_pending,
    .nmi_pending, .rd_wr_n, .port_b_out, .port_f_out, .port_c_out, .port_c_oe, .core_rdata, .bus_cycle_end);
  bcw_slow_mem mem_i (.ref_clk, .slow, .bus_clock, .rd_wr_n, .port_f_out, .port_c_out, .port_c_oe, .wait_in,
    .port_c_in);
  task automatic finish_test;
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_end(output int n);
    for (n = 1; n <= 40; n++) begin
      @(posedge ref_clk);
      #2;
      if (bus_cycle_end === 1'b1) return;
    end
    n_mismatch++;
    finish_test();
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    int n;
    logic held;
    tick(5);
    resetn = 1;
    wait_end(n);
    chk("op_mode", 16'(BCW_EXPANDED), 16'(op_mode));
    foreach (rows[i]) begin
      core_addr = rows[i].a;
      core_wdata = rows[i].d;
      core_write = rows[i].w;
      slow = rows[i].s;
      wait_end(n);
      wait_end(n);
      chk("cycle_len", rows[i].s ? 16'd8 : 16'd4, 16'(n));
      if (!rows[i].w) chk("core_rdata", 16'(rows[i].d), 16'(core_rdata));
    end
    for (int i = 1; i < 3; i++) begin
      {watchdog_fail, clock_monitor_fail} = 2'(i);
      tick(1);
      {watchdog_fail, clock_monitor_fail} = 2'b00;
      chk("reset_pin_oe", 16'd1, 16'(reset_pin_oe));
      tick(3);
    end
    instr_start = 1;
    tick(1);
    instr_start = 0;
    chk("marker_early", 16'd0, 16'(marker_oe));
    tick(1);
    chk("marker_oe", 16'd1, 16'(marker_oe));
    tick(1);
    chk("marker_end", 16'd0, 16'(marker_oe));
    held = bus_clock;
    clk_en = 0;
    tick(6);
    chk("frozen_clock", 16'(held), 16'(bus_clock));
    clk_en = 1;
    {irq_n, nonmaskable_interrupt_input, core_mask_i, core_mask_x} = 4'h0;
    tick(3);
    chk("irq_pending", 16'd1, 16'(irq_pending));
    chk("nmi_pending", 16'd1, 16'(nmi_pending));
    {core_mask_i, core_mask_x} = 2'b11;
    #1 chk("irq_masked", 16'd0, 16'(irq_pending));
    chk("nmi_masked", 16'd0, 16'(nmi_pending));
    for (int m = 3; m >= 0; m--) begin
      resetn = 0;
      {mode_select_second, mode_select_first} = 2'(m);
      tick(5);
      resetn = 1;
      tick(3);
      chk("op_mode", 16'(m), 16'(op_mode));
      if (m % 2 == 0) chk("port_b_gp", 16'(port_b_gp), 16'(port_b_out));
      if (m % 2 == 0) chk("rd_wr_n", 16'd1, 16'(rd_wr_n));
      if (m % 2 == 1) chk("port_b_addr", 16'h0000, 16'(port_b_out));
      chk("standby_active", 16'(m / 2), 16'(standby_active));
    end
    finish_test();
  end
endmodule // testbench
`default_nettype wire
